// ### rsu_pkg.sv
// Purpose: constants for the remote upgrade register set
// Assumes: one system clock; all pins but the asynchronous rst_n_i sampled into it
// Notes:   config word layout shared by control and staging regs
package rsu_pkg;
    // register widths
    localparam int CFG_W   = 21;
    localparam int CAUSE_W = 5;
    localparam int SHIFT_W = CFG_W + CAUSE_W;
    // config word fields
    localparam int APP_FLAG_BIT = 0;
    localparam int PAGE_LO_LSB  = 1;
    localparam int PAGE_LO_MSB  = 3;
    localparam int PAGE_HI_LSB  = 4;
    localparam int PAGE_HI_MSB  = 7;
    localparam int PAGE_MSB     = 7;
    localparam int TIMER_EN_BIT = 8;
    localparam int TIMEOUT_LSB  = 9;
    localparam int TIMEOUT_MSB  = 20;
    localparam int COUNT_W      = 29;
    localparam int COUNT_ZERO_W = 17;
    // cause record bits
    localparam int CAUSE_CRC    = 0;
    localparam int CAUSE_ERRPIN = 1;
    localparam int CAUSE_FABRIC = 2;
    localparam int CAUSE_RSTPIN = 3;
    localparam int CAUSE_TIMER  = 4;
    // reset values
    localparam logic [2:0] PAGE_LO_REMOTE_RST = 3'h0;
    localparam logic [2:0] PAGE_LO_LOCAL_RST  = 3'h1;
    localparam logic [3:0] PAGE_HI_RST        = 4'h0;
    localparam logic [CFG_W-1:0] CFG_ZERO     = 21'h00_0000;
    localparam logic [CAUSE_W-1:0] CAUSE_RST  = 5'h00;
    localparam logic [SHIFT_W-1:0] SHIFT_RST  = 26'h000_0000;
    // sync vector positions
    localparam int IN_UCLK  = 0;
    localparam int IN_SIN   = 1;
    localparam int IN_SHIFT = 2;
    localparam int IN_CAPT  = 3;
    localparam int IN_FREQN = 4;
    localparam int IN_CRC   = 5;
    localparam int IN_ERRN  = 6;
    localparam int IN_RSTN  = 7;
    localparam int IN_TMR   = 8;
    localparam int IN_RMT   = 9;
    localparam int IN_AS    = 10;
    localparam int IN_W     = 11;
    // straps settle through the synchroniser first
    localparam logic [1:0] INIT_CYCLES = 2'h3;
    typedef enum logic [1:0] {
        RSU_ST_INIT = 2'h1,
        RSU_ST_RUN  = 2'h2
    } rsu_state_e;
endpackage

// ### rsu_remote_upgrade_registers.sv
// Purpose: hard register set of the remote configuration upgrade unit
// Assumes: clk_sys_i stands in for the internal oscillator
// Notes:   upgrade_clock is sampled; shift and staging regs step on its rising edges

module rsu_remote_upgrade_registers (
    // clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         rst_n_i,
    // mode straps
    input  wire logic         remote_mode_i,
    input  wire logic         active_serial_scheme_i,
    // fabric shift port
    input  wire logic         upgrade_clock_i,
    input  wire logic         upgrade_serial_in_i,
    input  wire logic         shift_not_load_i,
    input  wire logic         capture_not_update_i,
    input  wire logic         fabric_reconfig_request_n_i,
    output logic              upgrade_serial_out_o,
    // reconfiguration causes
    input  wire logic         crc_error_i,
    input  wire logic         config_error_pin_n_i,
    input  wire logic         config_reset_pin_n_i,
    input  wire logic         timer_expiry_cause_i,
    // active configuration
    output logic [6:0]        page_select_o,
    output logic              application_flag_o,
    output logic              timer_enable_bit_o,
    output logic [11:0]       timeout_reload_field_o,
    output logic [4:0]        cause_record_o,
    output logic              reconfig_start_o
);

    // input synchronisers
    logic [rsu_pkg::IN_W-1:0] meta_reg;
    logic [rsu_pkg::IN_W-1:0] sync_reg;
    logic [rsu_pkg::IN_W-1:0] prev_reg;
    logic [rsu_pkg::IN_W-1:0] raw_in;

    assign raw_in = {active_serial_scheme_i, remote_mode_i,
                     timer_expiry_cause_i, config_reset_pin_n_i,
                     config_error_pin_n_i, crc_error_i,
                     fabric_reconfig_request_n_i, capture_not_update_i,
                     shift_not_load_i, upgrade_serial_in_i,
                     upgrade_clock_i};

    // meta_reg feeds sync_reg only
    genvar gi;
    generate
        for (gi = 0; gi < rsu_pkg::IN_W; gi++) begin : g_sync
            always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    meta_reg[gi] <= 1'b0;
                    sync_reg[gi] <= 1'b0;
                    prev_reg[gi] <= 1'b0;
                end else begin
                    meta_reg[gi] <= raw_in[gi];
                    sync_reg[gi] <= meta_reg[gi];
                    prev_reg[gi] <= sync_reg[gi];
                end
            end
        end
    endgenerate

    // registered state
    rsu_pkg::rsu_state_e         state_reg;
    rsu_pkg::rsu_state_e         state_next;
    logic [1:0]                  init_cnt_reg;
    logic [1:0]                  init_cnt_next;
    logic                        remote_reg;
    logic                        remote_next;
    logic                        as_reg;
    logic                        as_next;
    logic [rsu_pkg::CFG_W-1:0]   ctrl_reg;
    logic [rsu_pkg::CFG_W-1:0]   ctrl_next;
    logic [rsu_pkg::CFG_W-1:0]   update_reg;
    logic [rsu_pkg::CFG_W-1:0]   update_next;
    logic [rsu_pkg::CAUSE_W-1:0] cause_reg;
    logic [rsu_pkg::CAUSE_W-1:0] cause_next;
    logic [rsu_pkg::SHIFT_W-1:0] shift_reg;
    logic [rsu_pkg::SHIFT_W-1:0] shift_next;
    logic                        start_reg;
    logic                        start_next;

    // decoded events
    logic                        run;
    logic                        app_loaded;
    logic                        write_ok;
    logic                        uclk_rise;
    logic                        do_shift;
    logic                        do_capture;
    logic                        do_update;
    logic                        evt_crc;
    logic                        evt_err;
    logic                        evt_rst;
    logic                        evt_fab;
    logic                        evt_tmr;
    logic                        evt_fail;
    logic [rsu_pkg::CAUSE_W-1:0] evt_vec;
    logic [rsu_pkg::CFG_W-1:0]   staged_cfg;
    logic [rsu_pkg::CFG_W-1:0]   page_one_cfg;

    assign run        = (state_reg == rsu_pkg::RSU_ST_RUN);
    assign app_loaded = ctrl_reg[rsu_pkg::APP_FLAG_BIT];
    assign write_ok   = run && remote_reg && !app_loaded;
    // edges are found on the second stage, never on meta_reg
    assign uclk_rise  = sync_reg[rsu_pkg::IN_UCLK] && !prev_reg[rsu_pkg::IN_UCLK];
    assign do_shift   = run && uclk_rise && sync_reg[rsu_pkg::IN_SHIFT];
    assign do_capture = run && uclk_rise && !sync_reg[rsu_pkg::IN_SHIFT]
                        && sync_reg[rsu_pkg::IN_CAPT];
    assign do_update  = run && uclk_rise && !sync_reg[rsu_pkg::IN_SHIFT]
                        && !sync_reg[rsu_pkg::IN_CAPT] && write_ok;

    assign evt_crc  = run && sync_reg[rsu_pkg::IN_CRC] && !prev_reg[rsu_pkg::IN_CRC];
    assign evt_err  = run && !sync_reg[rsu_pkg::IN_ERRN] && prev_reg[rsu_pkg::IN_ERRN];
    assign evt_rst  = run && !sync_reg[rsu_pkg::IN_RSTN] && prev_reg[rsu_pkg::IN_RSTN];
    assign evt_fab  = run && sync_reg[rsu_pkg::IN_FREQN] && !prev_reg[rsu_pkg::IN_FREQN];
    // timer only counts while an application image runs with it enabled
    assign evt_tmr  = run && sync_reg[rsu_pkg::IN_TMR] && !prev_reg[rsu_pkg::IN_TMR]
                      && app_loaded && ctrl_reg[rsu_pkg::TIMER_EN_BIT];
    assign evt_fail = evt_crc || evt_err || evt_tmr;

    always_comb begin
        evt_vec = rsu_pkg::CAUSE_RST;
        evt_vec[rsu_pkg::CAUSE_CRC]    = evt_crc;
        evt_vec[rsu_pkg::CAUSE_ERRPIN] = evt_err;
        evt_vec[rsu_pkg::CAUSE_FABRIC] = evt_fab;
        evt_vec[rsu_pkg::CAUSE_RSTPIN] = evt_rst;
        evt_vec[rsu_pkg::CAUSE_TIMER]  = evt_tmr;
    end

    // staged word, page high kept zero outside remote active serial
    always_comb begin
        staged_cfg = update_reg;
        if (!(remote_reg && as_reg)) begin
            staged_cfg[rsu_pkg::PAGE_HI_MSB:rsu_pkg::PAGE_HI_LSB] =
                rsu_pkg::PAGE_HI_RST;
        end
    end

    // local-mode application word: page one, flag set
    always_comb begin
        page_one_cfg = rsu_pkg::CFG_ZERO;
        page_one_cfg[rsu_pkg::APP_FLAG_BIT] = 1'b1;
        page_one_cfg[rsu_pkg::PAGE_LO_MSB:rsu_pkg::PAGE_LO_LSB] =
            rsu_pkg::PAGE_LO_LOCAL_RST;
    end

    // next state of the whole block
    always_comb begin
        state_next    = state_reg;
        init_cnt_next = init_cnt_reg;
        remote_next   = remote_reg;
        as_next       = as_reg;
        ctrl_next     = ctrl_reg;
        update_next   = update_reg;
        cause_next    = cause_reg;
        shift_next    = shift_reg;
        start_next    = 1'b0;
        unique case (state_reg)
            rsu_pkg::RSU_ST_INIT: begin
                init_cnt_next = init_cnt_reg + 2'h1;
                if (init_cnt_reg == rsu_pkg::INIT_CYCLES) begin
                    // straps caught after release, not under reset
                    remote_next = sync_reg[rsu_pkg::IN_RMT];
                    as_next     = sync_reg[rsu_pkg::IN_AS];
                    if (sync_reg[rsu_pkg::IN_RMT]) begin
                        ctrl_next = rsu_pkg::CFG_ZERO;
                    end else begin
                        ctrl_next = page_one_cfg;
                    end
                    state_next = rsu_pkg::RSU_ST_RUN;
                end
            end
            rsu_pkg::RSU_ST_RUN: begin
                if (do_shift) begin
                    shift_next = {sync_reg[rsu_pkg::IN_SIN],
                                  shift_reg[rsu_pkg::SHIFT_W-1:1]};
                end else if (do_capture) begin
                    shift_next = {app_loaded ? ctrl_reg : update_reg,
                                  cause_reg};
                end else if (do_update) begin
                    update_next = shift_reg[rsu_pkg::SHIFT_W-1:rsu_pkg::CAUSE_W];
                end
                if (evt_fail || evt_rst || evt_fab) begin
                    cause_next = evt_vec;
                    start_next = 1'b1;
                    if (evt_fail) begin
                        ctrl_next = rsu_pkg::CFG_ZERO;
                    end else if (!remote_reg) begin
                        ctrl_next = page_one_cfg;
                    end else if (evt_rst) begin
                        ctrl_next = rsu_pkg::CFG_ZERO;
                    end else begin
                        ctrl_next = staged_cfg;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg    <= rsu_pkg::RSU_ST_INIT;
            init_cnt_reg <= 2'h0;
            remote_reg   <= 1'b0;
            as_reg       <= 1'b0;
            ctrl_reg     <= rsu_pkg::CFG_ZERO;
            update_reg   <= rsu_pkg::CFG_ZERO;
            cause_reg    <= rsu_pkg::CAUSE_RST;
            shift_reg    <= rsu_pkg::SHIFT_RST;
            start_reg    <= 1'b0;
        end else begin
            state_reg    <= state_next;
            init_cnt_reg <= init_cnt_next;
            remote_reg   <= remote_next;
            as_reg       <= as_next;
            ctrl_reg     <= ctrl_next;
            update_reg   <= update_next;
            cause_reg    <= cause_next;
            shift_reg    <= shift_next;
            start_reg    <= start_next;
        end
    end

    // outputs straight from flops
    assign upgrade_serial_out_o   = shift_reg[0];
    assign page_select_o          = ctrl_reg[rsu_pkg::PAGE_MSB:rsu_pkg::PAGE_LO_LSB];
    assign application_flag_o     = ctrl_reg[rsu_pkg::APP_FLAG_BIT];
    assign timer_enable_bit_o     = ctrl_reg[rsu_pkg::TIMER_EN_BIT];
    // low bits of the 29-bit count are implied zero
    assign timeout_reload_field_o = ctrl_reg[rsu_pkg::TIMEOUT_MSB:rsu_pkg::TIMEOUT_LSB];
    assign cause_record_o         = cause_reg;
    assign reconfig_start_o       = start_reg;

    // checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    a_update_write: assert property (
        do_update |=> update_reg == $past(shift_reg[rsu_pkg::SHIFT_W-1:rsu_pkg::CAUSE_W])
    ) else $error("staging write lost");

    a_update_blocked: assert property (
        (uclk_rise && !write_ok) |=> $stable(update_reg)
    ) else $error("staging written while blocked");

    a_update_path: assert property (
        run && !$stable(update_reg) |-> $past(do_update)
    ) else $error("staging changed without update");

    a_local_nowrite: assert property (
        run && $past(run) && !remote_reg && !reconfig_start_o |->
            $stable(ctrl_reg) && $stable(update_reg)
    ) else $error("register written in local mode");

    a_capture_app: assert property (
        do_capture && app_loaded |=>
            shift_reg[rsu_pkg::SHIFT_W-1:rsu_pkg::CAUSE_W] == $past(ctrl_reg)
    ) else $error("capture missed control word");

    a_capture_fact: assert property (
        do_capture && !app_loaded |=>
            shift_reg[rsu_pkg::SHIFT_W-1:rsu_pkg::CAUSE_W] == $past(update_reg)
    ) else $error("capture missed staging word");

    a_capture_cause: assert property (
        do_capture |=> shift_reg[rsu_pkg::CAUSE_W-1:0] == $past(cause_reg)
    ) else $error("capture missed cause record");

    a_shift_step: assert property (
        do_shift |=> shift_reg[rsu_pkg::SHIFT_W-2:0] ==
            $past(shift_reg[rsu_pkg::SHIFT_W-1:1])
            && upgrade_serial_out_o == $past(shift_reg[1])
    ) else $error("shift step wrong");

    a_cause_write: assert property (
        (evt_fail || evt_rst || evt_fab) |=>
            cause_record_o == $past(evt_vec) && reconfig_start_o
            ##1 (!reconfig_start_o || $past(evt_fail || evt_rst || evt_fab))
    ) else $error("cause record not written");

    a_fabric_copy: assert property (
        evt_fab && !evt_fail && !evt_rst && remote_reg && as_reg |=>
            ctrl_reg == $past(update_reg)
    ) else $error("staging word not copied");

    a_fallback_clr: assert property (
        evt_fail |=> !application_flag_o && page_select_o == 7'h00
    ) else $error("fall-back left flag set");

    a_timer_off: assert property (
        !app_loaded || !timer_enable_bit_o |=>
            !(reconfig_start_o && cause_record_o[rsu_pkg::CAUSE_TIMER])
    ) else $error("timer active in factory image");

    a_local_page: assert property (
        run && !remote_reg && application_flag_o |->
            page_select_o == {rsu_pkg::PAGE_HI_RST, rsu_pkg::PAGE_LO_LOCAL_RST}
    ) else $error("local page not one");

    a_start_cause: assert property (
        run && !$stable(cause_record_o) |-> reconfig_start_o
    ) else $error("cause changed without reconfiguration");

    a_page_hi_zero: assert property (
        run && !(remote_reg && as_reg) |->
            ctrl_reg[rsu_pkg::PAGE_HI_MSB:rsu_pkg::PAGE_HI_LSB] == rsu_pkg::PAGE_HI_RST
    ) else $error("page high not zero");

    a_powerup_val: assert property (
        state_reg == rsu_pkg::RSU_ST_INIT ##1 run |->
            ctrl_reg == (remote_reg ? rsu_pkg::CFG_ZERO : page_one_cfg)
    ) else $error("power-up control word wrong");

    c_capture: cover property (do_capture);
    c_update:  cover property (do_update ##[1:200] evt_fab);
    c_fallback: cover property (evt_fail && app_loaded);
    c_local_rst: cover property (evt_rst && !remote_reg);

endmodule

// ### rsu_fabric_model.sv
// Purpose: fabric user logic driving the upgrade shift port
// Assumes: upgrade clock period 125 ns, idle low between transfers
// Notes:   the serial line carries the inverse of its last bit when idle,
//          so a stale value is never mistaken for fresh data
module rsu_fabric_model (
    // from the register set
    input  wire logic upgrade_serial_out_i,
    // shift port
    output logic      upgrade_clock_o,
    output logic      upgrade_serial_in_o,
    output logic      shift_not_load_o,
    output logic      capture_not_update_o,
    output logic      fabric_reconfig_request_n_o
);
    timeunit 1ns;
    timeprecision 10ps;

    initial begin
        upgrade_clock_o             = 1'b0;
        upgrade_serial_in_o         = 1'b0;
        shift_not_load_o            = 1'b1;
        capture_not_update_o        = 1'b1;
        fabric_reconfig_request_n_o = 1'b1;
    end

    // one upgrade clock period; controls settle well before the rise
    task automatic step(input logic shift, input logic capt, input logic din);
        shift_not_load_o     = shift;
        capture_not_update_o = capt;
        upgrade_serial_in_o  = din;
        #31.25 upgrade_clock_o = 1'b1;
        #62.5  upgrade_clock_o = 1'b0;
        #31.25;
    endtask

    // capture then 25 shifts, bit 0 first
    task automatic read_word(output logic [25:0] w);
        step(1'b0, 1'b1, ~upgrade_serial_in_o);
        w[0] = upgrade_serial_out_i;
        for (int i = 1; i < 26; i++) begin
            step(1'b1, 1'b1, ~upgrade_serial_in_o);
            w[i] = upgrade_serial_out_i;
        end
        shift_not_load_o = 1'b1;
    endtask

    // 26 shifts then update; only bits 25:5 reach the staging register
    task automatic write_word(input logic [20:0] cfg);
        logic [25:0] v;
        v = {cfg, 5'h00};
        for (int i = 0; i < 26; i++) begin
            step(1'b1, 1'b1, v[i]);
        end
        step(1'b0, 1'b0, ~v[25]);
        shift_not_load_o     = 1'b1;
        capture_not_update_o = 1'b1;
    endtask

    // low then high; the rising edge is the request
    task automatic request_reconfig();
        fabric_reconfig_request_n_o = 1'b0;
        #40 fabric_reconfig_request_n_o = 1'b1;
    endtask
endmodule

// ### rsu_remote_upgrade_registers_tb.sv
// Purpose: self-checking bench for the remote upgrade register set
// Assumes: cause pins and straps driven here, shift port by the model
// Notes:   straps change only under reset, which is reapplied per mode
module rsu_remote_upgrade_registers_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk_sys_i = 1'b0;
    logic        rst_n_i   = 1'b0;
    logic        remote_mode, as_scheme, crc, err_n, rpin_n, tmr;
    logic        uclk, sin, shift_nld, capt_nupd, req_n, sout, start;
    logic [6:0]  page;
    logic        flag, ten;
    logic [11:0] tout;
    logic [4:0]  cause;
    logic [25:0] rd;
    int          failures    = 0;
    int          check_count = 0;
    int          cycles      = 0;

    localparam logic [20:0] W1  = {12'hC3A, 1'b1, 4'hA, 3'h5, 1'b1};
    localparam logic [20:0] W1P = {12'hC3A, 1'b1, 4'h0, 3'h5, 1'b1};
    localparam logic [20:0] W2  = {12'h001, 1'b0, 4'h3, 3'h2, 1'b1};
    localparam logic [20:0] LOC = {12'h000, 1'b0, 4'h0, 3'h1, 1'b1};
    localparam logic [20:0] Z   = rsu_pkg::CFG_ZERO;

    always #2 clk_sys_i = ~clk_sys_i;

    rsu_remote_upgrade_registers i_rsu_remote_upgrade_registers (
        .clk_sys_i                   (clk_sys_i),
        .rst_n_i                     (rst_n_i),
        .remote_mode_i               (remote_mode),
        .active_serial_scheme_i      (as_scheme),
        .upgrade_clock_i             (uclk),
        .upgrade_serial_in_i         (sin),
        .shift_not_load_i            (shift_nld),
        .capture_not_update_i        (capt_nupd),
        .fabric_reconfig_request_n_i (req_n),
        .upgrade_serial_out_o        (sout),
        .crc_error_i                 (crc),
        .config_error_pin_n_i        (err_n),
        .config_reset_pin_n_i        (rpin_n),
        .timer_expiry_cause_i        (tmr),
        .page_select_o               (page),
        .application_flag_o          (flag),
        .timer_enable_bit_o          (ten),
        .timeout_reload_field_o      (tout),
        .cause_record_o              (cause),
        .reconfig_start_o            (start)
    );

    rsu_fabric_model i_rsu_fabric_model (
        .upgrade_serial_out_i        (sout),
        .upgrade_clock_o             (uclk),
        .upgrade_serial_in_o         (sin),
        .shift_not_load_o            (shift_nld),
        .capture_not_update_o        (capt_nupd),
        .fabric_reconfig_request_n_o (req_n)
    );

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            summarize();
        end
    end

    task automatic check(input string what, input logic [25:0] exp, input logic [25:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [20:0] ctrl();
        return {tout, ten, page, flag};
    endfunction

    task automatic do_reset(input logic rm, input logic asc);
        rst_n_i     = 1'b0;
        remote_mode = rm;
        as_scheme   = asc;
        repeat (10) @(posedge clk_sys_i);
        #1 rst_n_i = 1'b1;
        repeat (8) @(posedge clk_sys_i);
        #1;
    endtask

    // which: 0 crc, 1 error pin, 2 fabric, 3 reset pin, 4 timer
    task automatic fire(input int which, input logic [4:0] ec, input logic [20:0] ew,
                        input logic es);
        logic seen;
        seen = 1'b0;
        @(posedge clk_sys_i);
        #1;
        case (which)
            0: crc = 1'b1;
            1: err_n = 1'b0;
            2: i_rsu_fabric_model.request_reconfig();
            3: rpin_n = 1'b0;
            default: tmr = 1'b1;
        endcase
        repeat (12) begin
            @(posedge clk_sys_i);
            #1;
            if (start === 1'b1) seen = 1'b1;
        end
        crc    = 1'b0;
        err_n  = 1'b1;
        rpin_n = 1'b1;
        tmr    = 1'b0;
        repeat (8) @(posedge clk_sys_i);
        #1;
        check("start", {25'h000_0000, es}, {25'h000_0000, seen});
        check("cause", {21'h00_0000, ec}, {21'h00_0000, cause});
        check("control", {5'h00, ew}, {5'h00, ctrl()});
    endtask

    task automatic read_chk(input logic [20:0] ew, input logic [4:0] ec);
        i_rsu_fabric_model.read_word(rd);
        check("shift word", {ew, ec}, rd);
    endtask

    initial begin
        {crc, tmr}      = 2'b00;
        {err_n, rpin_n} = 2'b11;
        do_reset(1'b1, 1'b1);
        check("control", {5'h00, Z}, {5'h00, ctrl()});
        check("cause", 26'h000_0000, {21'h00_0000, cause});
        read_chk(Z, 5'h00);
        $display("test remote power-up done");
        i_rsu_fabric_model.write_word(W1);
        read_chk(W1, 5'h00);
        check("control", {5'h00, Z}, {5'h00, ctrl()});
        $display("test staging write done");
        fire(2, 5'h04, W1, 1'b1);
        read_chk(W1, 5'h04);
        i_rsu_fabric_model.write_word(W2);
        read_chk(W1, 5'h04);
        fire(2, 5'h04, W1, 1'b1);
        $display("test application image done");
        fire(4, 5'h10, Z, 1'b1);
        fire(4, 5'h10, Z, 1'b0);
        read_chk(W1, 5'h10);
        fire(0, 5'h01, Z, 1'b1);
        fire(1, 5'h02, Z, 1'b1);
        fire(3, 5'h08, Z, 1'b1);
        $display("test causes done");
        do_reset(1'b1, 1'b0);
        check("control", {5'h00, Z}, {5'h00, ctrl()});
        i_rsu_fabric_model.write_word(W1);
        fire(2, 5'h04, W1P, 1'b1);
        $display("test parallel scheme done");
        do_reset(1'b0, 1'b0);
        check("control", {5'h00, LOC}, {5'h00, ctrl()});
        i_rsu_fabric_model.write_word(W2);
        fire(2, 5'h04, LOC, 1'b1);
        read_chk(LOC, 5'h04);
        fire(0, 5'h01, Z, 1'b1);
        read_chk(Z, 5'h01);
        fire(3, 5'h08, LOC, 1'b1);
        fire(4, 5'h08, LOC, 1'b0);
        $display("test local mode done");
        summarize();
    end
endmodule
